/* rtl/fao_pkg.sv */
package fao_pkg;

  // Converter geometry
  localparam int CODE_W    = 4;
  localparam int CMP_N     = 16;
  localparam int SYNC_N    = 3;

  // Avalon-MM register map, byte addresses
  localparam int ADDR_W    = 4;
  localparam int DATA_W    = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'hc;

  // CTRL fields
  localparam int CTRL_CONV_EN_BIT = 0;
  localparam logic CTRL_RESET     = 1'b1;

  // STATUS fields
  localparam int ST_CODE_LSB  = 0;
  localparam int ST_OVF_BIT   = 4;
  localparam int ST_CHG_BIT   = 5;
  localparam int ST_ALL_EN_BIT  = 8;
  localparam int ST_DATA_DIS_BIT = 9;

  // Interrupt events, same layout in status and mask
  localparam int IRQ_W        = 2;
  localparam int IRQ_CHG_BIT  = 0;
  localparam int IRQ_OVF_BIT  = 1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

  // Full code shown while over range
  localparam logic [CODE_W-1:0] CODE_FULL = 4'hf;

  typedef struct packed {
    logic              ovf;
    logic [CODE_W-1:0] code;
    logic              chg;
  } fao_sample_s;

  localparam fao_sample_s SAMPLE_RESET = '{ovf: 1'b0, code: 4'h0, chg: 1'b0};

endpackage

/* rtl/fao_output_stage.sv */
// Function
// R01: All-outputs enable low three-states data bits and both flags, whatever else.
// R02: Data-bits enable touches only the four data drivers, never the flags.
// R03: With all enabled, data driven when data enable low, three-stated when high.
// R04: Straight binary 0..15, lsb bit 0; overflow forces all bits high, count 31.
// R05: Code-changed flag high when new output differs from previous conversion.
// R06: Comparators latched on falling edge, decoded code registered on next rising edge.
// R07: Overflow flag set when input exceeds 31/32 of span, data bits held high.
// R08: Capturing logic samples outputs only when driven and after settling; the capture model samples every falling edge, driven or not.
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
module fao_output_stage
  import fao_pkg::*;
(
  input  wire logic                       mclk_i,
  input  wire logic                       rst_i,
  input  wire logic [fao_pkg::CMP_N-1:0]  comparators_i,
  input  wire logic                       data_bits_output_enable_n_i,
  input  wire logic                       all_outputs_enable_i,
  output logic [fao_pkg::CODE_W-1:0]      code_bits_o,
  output logic                            code_bits_oe_n_o,
  output logic                            over_range_flag_o,
  output logic                            code_changed_flag_o,
  output logic                            flags_oe_n_o,
  input  wire logic [fao_pkg::ADDR_W-1:0] avs_address_i,
  input  wire logic                       avs_read_i,
  input  wire logic                       avs_write_i,
  input  wire logic [3:0]                 avs_byteenable_i,
  input  wire logic [fao_pkg::DATA_W-1:0] avs_writedata_i,
  output logic [fao_pkg::DATA_W-1:0]      avs_readdata_o,
  output logic                            avs_waitrequest_o,
  output logic                            irq_o
);
  import fao_pkg::*;

  // Thermometer to binary: count of low taps that tripped, top tap is overflow
  function automatic fao_sample_s decode(input logic [CMP_N-1:0] t);
    fao_sample_s s;
    logic [CODE_W-1:0] n;
    n = '0;
    for (int i = 0; i < CMP_N - 1; i++) begin
      n = n + CODE_W'(t[i]);
    end
    s.ovf  = t[CMP_N-1];
    s.code = t[CMP_N-1] ? CODE_FULL : n;
    s.chg  = 1'b0;
    return s;
  endfunction

  // Comparator latch on the falling edge; ends the sample phase
  logic [CMP_N-1:0] latch_reg;
  always_ff @(negedge mclk_i) begin
    if (rst_i) begin
      latch_reg <= '0;
    end else begin
      latch_reg <= comparators_i; // R06
    end
  end

  // Enable pins: three stages, a change counts when the last two agree
  logic [SYNC_N-1:0] all_sync_reg;
  logic [SYNC_N-1:0] dis_sync_reg;
  logic              all_en_reg;
  logic              all_en_next;
  logic              data_dis_reg;
  logic              data_dis_next;
  logic              data_oe_n_reg;
  logic              data_oe_n_next;
  logic              flag_oe_n_reg;
  logic              flag_oe_n_next;

  always_comb begin
    all_en_next   = (all_sync_reg[1] == all_sync_reg[2]) ? all_sync_reg[2] : all_en_reg;
    data_dis_next = (dis_sync_reg[1] == dis_sync_reg[2]) ? dis_sync_reg[2] : data_dis_reg;
    flag_oe_n_next = ~all_en_reg;                   // R01 R02
    data_oe_n_next = ~(all_en_reg & ~data_dis_reg); // R01 R03
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      all_sync_reg  <= '0;
      dis_sync_reg  <= '1;
      all_en_reg    <= 1'b0;
      data_dis_reg  <= 1'b1;
      data_oe_n_reg <= 1'b1;
      flag_oe_n_reg <= 1'b1;
    end else begin
      all_sync_reg  <= {all_sync_reg[1:0], all_outputs_enable_i};
      dis_sync_reg  <= {dis_sync_reg[1:0], data_bits_output_enable_n_i};
      all_en_reg    <= all_en_next;
      data_dis_reg  <= data_dis_next;
      data_oe_n_reg <= data_oe_n_next;
      flag_oe_n_reg <= flag_oe_n_next;
    end
  end

  // Output registers and change detect
  fao_sample_s sample_reg;
  fao_sample_s sample_next;
  fao_sample_s decoded;
  logic        conv_en_reg;
  logic        conv_en_next;

  always_comb begin
    decoded     = decode(latch_reg); // R04 R07
    sample_next = sample_reg;
    if (conv_en_reg) begin
      sample_next     = decoded; // R06
      // Compare both code and overflow, i.e. the full five-bit result
      sample_next.chg = {decoded.ovf, decoded.code} != {sample_reg.ovf, sample_reg.code}; // R05
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sample_reg <= SAMPLE_RESET;
    end else begin
      sample_reg <= sample_next;
    end
  end

  // Avalon slave: one wait cycle, so read data is registered, not decoded live
  logic             wait_reg;
  logic             wait_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_stat_next;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_mask_next;
  logic             irq_reg;
  logic             irq_next;
  logic             req;
  logic             done;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] clr;

  always_comb begin
    req        = avs_read_i | avs_write_i;
    done       = req & ~wait_reg;
    wait_next  = ~(req & wait_reg);
    rdata_next = '0;
    case (avs_address_i)
      OFS_CTRL:     rdata_next[CTRL_CONV_EN_BIT] = conv_en_reg;
      OFS_STATUS: begin
        rdata_next[ST_CODE_LSB +: CODE_W] = sample_reg.code;
        rdata_next[ST_OVF_BIT]      = sample_reg.ovf;
        rdata_next[ST_CHG_BIT]      = sample_reg.chg;
        rdata_next[ST_ALL_EN_BIT]   = all_en_reg;
        rdata_next[ST_DATA_DIS_BIT] = data_dis_reg;
      end
      OFS_IRQ_STAT: rdata_next[IRQ_W-1:0] = irq_stat_reg;
      OFS_IRQ_MASK: rdata_next[IRQ_W-1:0] = irq_mask_reg;
      default:      rdata_next = '0;
    endcase

    conv_en_next  = conv_en_reg;
    irq_mask_next = irq_mask_reg;
    if (done && avs_write_i && avs_byteenable_i[0]) begin
      case (avs_address_i)
        OFS_CTRL:     conv_en_next  = avs_writedata_i[CTRL_CONV_EN_BIT];
        OFS_IRQ_MASK: irq_mask_next = avs_writedata_i[IRQ_W-1:0];
        default:      conv_en_next  = conv_en_reg;
      endcase
    end

    // A new event in the clearing cycle survives the clear
    events = '0;
    events[IRQ_CHG_BIT] = sample_next.chg & conv_en_reg;
    events[IRQ_OVF_BIT] = sample_next.ovf & conv_en_reg;
    // Clear only what the completing read reported; an event landing in the wait cycle stays
    clr = (done && avs_read_i && avs_address_i == OFS_IRQ_STAT) ? rdata_reg[IRQ_W-1:0] : '0;
    irq_stat_next = (irq_stat_reg & ~clr) | events;
    irq_next      = |(irq_stat_next & irq_mask_next);
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wait_reg     <= 1'b1;
      rdata_reg    <= '0;
      conv_en_reg  <= CTRL_RESET;
      irq_stat_reg <= '0;
      irq_mask_reg <= IRQ_MASK_RESET;
      irq_reg      <= 1'b0;
    end else begin
      wait_reg     <= wait_next;
      rdata_reg    <= rdata_next;
      conv_en_reg  <= conv_en_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg      <= irq_next;
    end
  end

  // Data stays in the register even when three-stated; the pad uses the enables
  assign code_bits_o         = sample_reg.code; // R04
  assign over_range_flag_o   = sample_reg.ovf;  // R07
  assign code_changed_flag_o = sample_reg.chg;  // R05
  assign code_bits_oe_n_o    = data_oe_n_reg;
  assign flags_oe_n_o        = flag_oe_n_reg;
  assign avs_readdata_o      = rdata_reg;
  assign avs_waitrequest_o   = wait_reg;
  assign irq_o               = irq_reg;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_all_off_tristate: assert property (!all_en_reg |=> flags_oe_n_o && code_bits_oe_n_o) // R01
    else $error("outputs driven while all-outputs enable low");
  a_flags_ignore_data: assert property (all_en_reg && data_dis_reg |=> !flags_oe_n_o && code_bits_oe_n_o) // R02
    else $error("flags not driven or data driven with data enable high");
  a_data_drive_on: assert property (all_en_reg && !data_dis_reg |=> !code_bits_oe_n_o) // R03
    else $error("data bits not driven when enabled");
  a_overflow_full: assert property (over_range_flag_o |-> code_bits_o == CODE_FULL) // R04
    else $error("overflow without all data bits high");
  a_code_follows: assert property (conv_en_reg |=> code_bits_o == $past(decoded.code)) // R06
    else $error("output code not loaded from latched comparators");
  a_change_flag: assert property (conv_en_reg |=> code_changed_flag_o ==
      ({$past(decoded.ovf), $past(decoded.code)} != {$past(sample_reg.ovf), $past(sample_reg.code)})) // R05
    else $error("code changed flag wrong");
  a_top_tap_ovf: assert property (conv_en_reg && latch_reg[CMP_N-1] |=> over_range_flag_o) // R07
    else $error("top comparator did not raise overflow");
  a_bus_one_wait: assert property (req && wait_reg |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not after exactly one wait cycle");

endmodule

/* dv/fao_capture_model.sv */
module fao_capture_model
  import fao_pkg::*;
(
  input  wire logic                       mclk_i,
  input  wire logic [fao_pkg::CODE_W-1:0] code_bits_i,
  input  wire logic                       code_bits_oe_n_i,
  input  wire logic                       over_range_flag_i,
  input  wire logic                       code_changed_flag_i,
  input  wire logic                       flags_oe_n_i,
  output fao_pkg::fao_sample_s            cap_o
);
  timeunit 1ns;
  timeprecision 1ps;
  fao_sample_s pins;
  // A released driver floats, so the capture sees high impedance
  assign pins = '{ovf: flags_oe_n_i ? 1'bz : over_range_flag_i,
                  code: code_bits_oe_n_i ? 4'bz : code_bits_i,
                  chg: flags_oe_n_i ? 1'bz : code_changed_flag_i};
  // Half a cycle after the load edge the pins have settled
  always @(negedge mclk_i) cap_o <= pins;
endmodule

/* dv/tb_top.sv */
module tb_top
  import fao_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              mclk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic [CMP_N-1:0]  comparators_i = '0;
  logic              data_bits_output_enable_n_i = 1'b1;
  logic              all_outputs_enable_i = 1'b0;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic              avs_read_i = 1'b0;
  logic              avs_write_i = 1'b0;
  logic [3:0]        avs_byteenable_i = 4'h1;
  logic [DATA_W-1:0] avs_writedata_i = '0;
  logic [DATA_W-1:0] avs_readdata_o;
  logic [CODE_W-1:0] code_bits_o;
  logic              code_bits_oe_n_o, over_range_flag_o, code_changed_flag_o;
  logic              flags_oe_n_o, avs_waitrequest_o, irq_o;
  fao_sample_s       cap;
  logic [31:0]       lfsr_q = 32'h11022b37;
  logic [31:0]       rd;
  int                bad_count, checked, prv, e_code, e_ovf, e_chg;
  bit                en = 1'b1;
  always #2 mclk_i = ~mclk_i;
  fao_output_stage u_dut (.mclk_i, .rst_i, .comparators_i, .data_bits_output_enable_n_i,
    .all_outputs_enable_i, .code_bits_o, .code_bits_oe_n_o, .over_range_flag_o,
    .code_changed_flag_o, .flags_oe_n_o, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .irq_o);
  fao_capture_model u_cap (.mclk_i, .code_bits_i(code_bits_o), .code_bits_oe_n_i(code_bits_oe_n_o),
    .over_range_flag_i(over_range_flag_o), .code_changed_flag_i(code_changed_flag_o),
    .flags_oe_n_i(flags_oe_n_o), .cap_o(cap));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %s ended", s);
  endtask
  task automatic bus(input bit wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    // Only the watchdog ends a wait that never completes
    do begin
      @(posedge mclk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic settle;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask
  // Drives v tripped taps, then checks the result of the next load edge
  task automatic conv(input int v);
    logic [4:0] full;
    bit         de, ae;
    @(posedge mclk_i);
    comparators_i <= 16'hffff >> (16 - v);
    @(posedge mclk_i);
    @(negedge mclk_i);
    #1;
    full = (v == 16) ? 5'h1f : 5'(v);
    ae = all_outputs_enable_i;
    de = ae && !data_bits_output_enable_n_i;
    if (en) begin
      e_chg = int'(full != 5'(prv));
      prv = int'(full);
      e_code = int'(full[3:0]);
      e_ovf = int'(full[4]);
    end
    chk(code_bits_o, e_code, "code");
    chk(over_range_flag_o, e_ovf, "ovf");
    chk(code_changed_flag_o, e_chg, "chg");
    chk(code_bits_oe_n_o, !de, "data oe");
    chk(flags_oe_n_o, !ae, "flag oe");
    chk(cap.code, de ? 4'(e_code) : 4'bz, "code pins");
    chk({cap.ovf, cap.chg}, ae ? {1'(e_ovf), 1'(e_chg)} : 2'bzz, "flag pins");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk_i);
    bad_count++;
    final_report;
  end
  initial begin
    int b[6];
    b = '{0, 15, 16, 16, 14, 0};
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(negedge mclk_i);
    chk({code_bits_oe_n_o, flags_oe_n_o, avs_waitrequest_o, irq_o, code_bits_o}, 8'he0, "reset");
    done("reset");
    for (int k = 0; k < 5; k++) begin
      @(posedge mclk_i);
      all_outputs_enable_i <= (k >= 2);
      data_bits_output_enable_n_i <= k[0];
      repeat (8) @(posedge mclk_i);
      repeat (3) begin
        lfsr_q = lfsr(lfsr_q);
        conv(int'(lfsr_q % 17));
      end
    end
    done("enables");
    foreach (b[i]) conv(b[i]);
    repeat (30) begin
      lfsr_q = lfsr(lfsr_q);
      conv(int'(lfsr_q % 17));
    end
    done("conversions");
    bus(0, OFS_CTRL, 0);
    chk(rd[0], 1'b1, "ctrl reset");
    bus(0, OFS_IRQ_MASK, 0);
    chk(rd[1:0], IRQ_MASK_RESET, "mask reset");
    bus(0, OFS_STATUS, 0);
    chk(rd[9:0], {2'b01, 3'b000, 5'(prv)}, "status");
    bus(0, 4'h2, 0);
    chk(rd, 0, "unmapped");
    avs_byteenable_i <= 4'he;
    bus(1, OFS_IRQ_MASK, 32'h3);
    avs_byteenable_i <= 4'h1;
    bus(1, 4'h2, 32'h3);
    bus(0, OFS_IRQ_MASK, 0);
    chk(rd[1:0], 2'h0, "ignored writes");
    done("registers");
    conv(3);
    bus(1, OFS_IRQ_MASK, 32'h3);
    bus(0, OFS_IRQ_MASK, 0);
    chk(rd[1:0], 2'h3, "mask written");
    bus(0, OFS_IRQ_STAT, 0);
    settle;
    chk(irq_o, 1'b0, "irq idle");
    conv(16);
    bus(0, OFS_STATUS, 0);
    chk(rd[4:0], 5'h1f, "status ovf");
    conv(5);
    chk(irq_o, 1'b1, "irq raised");
    bus(0, OFS_IRQ_STAT, 0);
    chk(rd[1:0], 2'h3, "irq events");
    settle;
    chk(irq_o, 1'b0, "irq cleared");
    bus(1, OFS_IRQ_MASK, 32'h2);
    conv(9);
    settle;
    chk(irq_o, 1'b0, "irq masked");
    bus(0, OFS_IRQ_STAT, 0);
    chk(rd[1:0], 2'h1, "chg event");
    done("irq");
    bus(1, OFS_CTRL, 0);
    bus(0, OFS_CTRL, 0);
    chk(rd[0], 1'b0, "ctrl off");
    // Input was steady for many loads before the stop, so the held flag is low
    e_chg = 0;
    en = 1'b0;
    conv(12);
    bus(1, OFS_CTRL, 1);
    en = 1'b1;
    prv = 12;
    conv(12);
    done("hold");
    final_report;
  end
endmodule
